// >>> autoreclose_shot_sequencer.v
// Autoreclose shot sequencer with APB register port and breaker command outputs
//
// Contract
// - Report the shot now executing, numbered one to five.
// - Count failed shots and, separately, total sequence starts.
// - Five per-shot start counters for each of the first two request lines.
// - Fault on a request line starts the shot one start delay.
// - Start delay expiry asserts the open-breaker output.
// - Breaker open drops the open command and starts the shot dead time.
// - Dead time expiry asserts the close-breaker output.
// - Breaker closed drops the close command and starts discrimination time.
// - Fault still present at discrimination expiry trips again, then next shot if enabled, else final trip.
// - Fault gone after reclose starts reclaim; reclaim expiry means success.
// - After success wait for a new request, starting again at shot one.
// - Per-shot dead time, 0.02 to 300.00 s, default 5.00 s.
// - One reclaim time, 0.02 to 300.00 s, default 10.00 s.
// - Active close-block input withholds closing; close at once when released.
// - Per line and shot: enable, start delay, discrimination, 0.02 to 300.00 s.
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defines.vh"

module autoreclose_shot_sequencer #(
    parameter TICK_CYCLES = `AR_TICK_NS / `AR_CLK_NS,
    parameter CNT_W       = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [3:0]  req_lines,
    input  wire        breaker_open_fb,
    input  wire        breaker_closed_fb,
    input  wire        close_block_input,
    output reg         open_breaker_output,
    output reg         close_breaker_output,
    output reg         irq
);
    localparam [3:0] ST_INIT = 4'h0, ST_RECLAIM = 4'h1, ST_READY = 4'h2, ST_WAIT_OPEN = 4'h3,
                     ST_WAIT_CLOSE = 4'h4, ST_DISCR = 4'h5, ST_LOCKED = 4'h6, ST_FINAL = 4'h7,
                     ST_CBFAIL = 4'h8, ST_INHIBIT = 4'h9, ST_START = 4'ha, ST_DEAD = 4'hb;
    localparam [1:0] TM_RECLAIM = 2'h0, TM_START = 2'h1, TM_DEAD = 2'h2, TM_DISCR = 2'h3;
    localparam [23:0] TICK_LAST = TICK_CYCLES - 1;

    function [14:0] clamp_time;
        input [14:0] v;
        begin
            if (v < `AR_TIME_MIN)
                clamp_time = `AR_TIME_MIN;
            else if (v > `AR_TIME_MAX)
                clamp_time = `AR_TIME_MAX;
            else
                clamp_time = v;
        end
    endfunction

    // Pins are asynchronous to pclk
    reg  [6:0]       sync1;
    reg  [6:0]       sync2;
    wire [3:0]       req_s     = sync2[3:0];
    wire             brk_open  = sync2[4];
    wire             brk_close = sync2[5];
    wire             blk_s     = sync2[6];

    reg  [1:0]       ctrl;
    reg  [14:0]      reclaim_t;
    reg  [`AR_IRQ_W-1:0] irq_stat;
    reg  [`AR_IRQ_W-1:0] irq_mask;
    reg  [`AR_IRQ_W-1:0] ev;
    reg  [CNT_W-1:0] starts_cnt;
    reg  [CNT_W-1:0] fails_cnt;
    reg  [3:0]       state;
    reg  [2:0]       shot_ix;
    reg  [1:0]       line;
    reg              final_pend;
    reg  [1:0]       tcode;
    reg              trun;
    reg              ld;
    reg  [14:0]      ld_val;
    reg  [14:0]      tmr;
    reg  [23:0]      pre;
    reg              inc_total;
    reg              inc_fail;
    reg              inc_shot;

    wire [31:0]      cfg_w   [0:19];
    wire [14:0]      dead_w  [0:4];
    wire [CNT_W-1:0] shot_w  [0:9];

    wire        ar_en   = ctrl[`AR_CTRL_ENABLE];
    wire        blocked = ctrl[`AR_CTRL_BLOCK_EN] & blk_s;
    wire        fault   = |req_s;
    wire        tdone   = (tmr == 15'h0000) & ~ld;
    wire [7:0]  a       = {paddr[7:2], 2'b00};
    wire        wr      = psel & penable & pready & pwrite;
    wire [4:0]  cur_i   = {1'b0, line, 2'b00} + {3'b000, line} + {2'b00, shot_ix};
    wire [4:0]  nxt_i   = cur_i + 5'h01;
    wire [3:0]  sc_i    = {1'b0, line[0], 2'b00} + {3'b000, line[0]} + {1'b0, shot_ix};
    wire [31:0] cur_cfg = cfg_w[cur_i];
    wire [7:0]  cfg_off = a - `AR_OFF_CFG0;
    wire [7:0]  dead_off = a - `AR_OFF_DEAD0;
    wire [7:0]  sc_off  = a - `AR_OFF_SHOTCNT0;

    // Lowest active request line whose shot one is enabled
    reg         hit;
    reg  [1:0]  hit_line;
    integer     k;
    always @*
    begin
        hit = 1'b0;
        hit_line = 2'b00;
        for (k = 3; k >= 0; k = k - 1)
            if (req_s[k] && cfg_w[k * 5][`AR_CFG_EN_BIT])
            begin
                hit = 1'b1;
                hit_line = k[1:0];
            end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
        end
        else
        begin
            sync1 <= {close_block_input, breaker_closed_fb, breaker_open_fb, req_lines};
            sync2 <= sync1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 20; i = i + 1)
        begin : g_cfg
            localparam [7:0] ADDR = `AR_OFF_CFG0 + 4 * i;
            reg [31:0] r;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    r <= {1'b0, 1'b0, `AR_DELAY_RESET, `AR_DELAY_RESET};
                else if (wr && a == ADDR)
                    r <= {pwdata[31], 1'b0, clamp_time(pwdata[29:15]),
                          clamp_time(pwdata[14:0])};
            end
            assign cfg_w[i] = r;
        end
        for (i = 0; i < 5; i = i + 1)
        begin : g_dead
            localparam [7:0] ADDR = `AR_OFF_DEAD0 + 4 * i;
            reg [14:0] r;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    r <= `AR_DEAD_RESET;
                else if (wr && a == ADDR)
                    r <= clamp_time(pwdata[14:0]);
            end
            assign dead_w[i] = r;
        end
        for (i = 0; i < 10; i = i + 1)
        begin : g_shotcnt
            localparam [7:0] ADDR = `AR_OFF_SHOTCNT0 + 4 * i;
            localparam [3:0] IX = i;
            reg [CNT_W-1:0] r;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    r <= {CNT_W{1'b0}};
                else if (inc_shot && !line[1] && sc_i == IX)
                    r <= (wr && a == ADDR) ? {{(CNT_W-1){1'b0}}, 1'b1} : r + 1'b1;
                else if (wr && a == ADDR)
                    r <= {CNT_W{1'b0}};
            end
            assign shot_w[i] = r;
        end
    endgenerate

    // Register port, interrupt and counters; a count event beats a software clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `AR_CTRL_RESET;
            reclaim_t <= `AR_RECLAIM_RESET;
            irq_mask <= {`AR_IRQ_W{1'b0}};
            irq_stat <= {`AR_IRQ_W{1'b0}};
            irq <= 1'b0;
            starts_cnt <= {CNT_W{1'b0}};
            fails_cnt <= {CNT_W{1'b0}};
        end
        else
        begin
            if (wr && a == `AR_OFF_CTRL)
                ctrl <= pwdata[1:0];
            if (wr && a == `AR_OFF_RECLAIM)
                reclaim_t <= clamp_time(pwdata[14:0]);
            if (wr && a == `AR_OFF_IRQ_MASK)
                irq_mask <= pwdata[`AR_IRQ_W-1:0];
            irq_stat <= (irq_stat & ~((wr && a == `AR_OFF_IRQ_STAT) ?
                         pwdata[`AR_IRQ_W-1:0] : {`AR_IRQ_W{1'b0}})) | ev;
            irq <= |(irq_stat & irq_mask);
            if (inc_total)
                starts_cnt <= (wr && a == `AR_OFF_STARTS) ? {{(CNT_W-1){1'b0}}, 1'b1}
                              : starts_cnt + 1'b1;
            else if (wr && a == `AR_OFF_STARTS)
                starts_cnt <= {CNT_W{1'b0}};
            if (inc_fail)
                fails_cnt <= (wr && a == `AR_OFF_FAILS) ? {{(CNT_W-1){1'b0}}, 1'b1}
                             : fails_cnt + 1'b1;
            else if (wr && a == `AR_OFF_FAILS)
                fails_cnt <= {CNT_W{1'b0}};
        end
    end

    // Read mux; status shows internal phases under the nearest reported state
    reg  [31:0] rmux;
    reg         rhit;
    reg  [3:0]  code;
    always @*
    begin
        case (state)
            ST_START: code = ST_READY;
            ST_DEAD:  code = ST_WAIT_CLOSE;
            default:  code = state;
        endcase
        rhit = 1'b1;
        rmux = 32'h0000_0000;
        if (a == `AR_OFF_CTRL)
            rmux = {30'h0000_0000, ctrl};
        else if (a == `AR_OFF_STATUS)
            rmux = {21'h00_0000, trun, tcode, 1'b0, shot_ix + 3'h1, code};
        else if (a == `AR_OFF_IRQ_STAT)
            rmux[`AR_IRQ_W-1:0] = irq_stat;
        else if (a == `AR_OFF_IRQ_MASK)
            rmux[`AR_IRQ_W-1:0] = irq_mask;
        else if (a == `AR_OFF_RECLAIM)
            rmux[14:0] = reclaim_t;
        else if (a == `AR_OFF_STARTS)
            rmux[CNT_W-1:0] = starts_cnt;
        else if (a == `AR_OFF_FAILS)
            rmux[CNT_W-1:0] = fails_cnt;
        else if (a >= `AR_OFF_DEAD0 && dead_off < 8'h14)
            rmux[14:0] = dead_w[dead_off[4:2]];
        else if (a >= `AR_OFF_CFG0 && cfg_off < 8'h50)
            rmux = cfg_w[cfg_off[6:2]];
        else if (a >= `AR_OFF_SHOTCNT0 && sc_off < 8'h28)
            rmux[CNT_W-1:0] = shot_w[sc_off[5:2]];
        else
            rhit = 1'b0;
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~rhit;
            if (psel && penable && !pready && !pwrite)
                prdata <= rmux;
        end
    end

    // Interval timer in 10 ms ticks
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmr <= 15'h0000;
            pre <= 24'h00_0000;
        end
        else if (ld)
        begin
            tmr <= ld_val;
            pre <= 24'h00_0000;
        end
        else if (tmr != 15'h0000)
        begin
            if (pre == TICK_LAST)
            begin
                pre <= 24'h00_0000;
                tmr <= tmr - 15'h0001;
            end
            else
                pre <= pre + 24'h00_0001;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_INIT;
            shot_ix <= 3'h0;
            line <= 2'h0;
            final_pend <= 1'b0;
            tcode <= TM_RECLAIM;
            trun <= 1'b0;
            ld <= 1'b0;
            ld_val <= 15'h0000;
            ev <= {`AR_IRQ_W{1'b0}};
            inc_total <= 1'b0;
            inc_fail <= 1'b0;
            inc_shot <= 1'b0;
            open_breaker_output <= 1'b0;
            close_breaker_output <= 1'b0;
        end
        else
        begin
            ld <= 1'b0;
            ev <= {`AR_IRQ_W{1'b0}};
            inc_total <= 1'b0;
            inc_fail <= 1'b0;
            inc_shot <= 1'b0;
            case (state)
                ST_INIT:
                    state <= ST_READY;
                ST_READY:
                    if (!ar_en)
                        state <= ST_INHIBIT;
                    else if (fault && hit)
                    begin
                        line <= hit_line;
                        shot_ix <= 3'h0;
                        final_pend <= 1'b0;
                        ld <= 1'b1;
                        ld_val <= cfg_w[{1'b0, hit_line, 2'b00} + {3'b000, hit_line}][14:0];
                        tcode <= TM_START;
                        trun <= 1'b1;
                        inc_total <= 1'b1;
                        inc_shot <= 1'b1;
                        ev[`AR_IRQ_SHOT] <= 1'b1;
                        state <= ST_START;
                    end
                ST_START:
                    if (!fault)
                    begin
                        trun <= 1'b0;
                        state <= ST_READY;
                    end
                    else if (tdone)
                    begin
                        open_breaker_output <= 1'b1;
                        ld <= 1'b1;
                        ld_val <= `AR_CB_TIMEOUT;
                        trun <= 1'b0;
                        state <= ST_WAIT_OPEN;
                    end
                ST_WAIT_OPEN:
                    if (brk_open)
                    begin
                        open_breaker_output <= 1'b0;
                        if (final_pend)
                        begin
                            ev[`AR_IRQ_FINAL] <= 1'b1;
                            state <= ST_FINAL;
                        end
                        else
                        begin
                            ld <= 1'b1;
                            ld_val <= dead_w[shot_ix];
                            tcode <= TM_DEAD;
                            trun <= 1'b1;
                            state <= ST_DEAD;
                        end
                    end
                    else if (tdone)
                    begin
                        open_breaker_output <= 1'b0;
                        ev[`AR_IRQ_CBFAIL] <= 1'b1;
                        state <= ST_CBFAIL;
                    end
                ST_DEAD:
                    if (tdone)
                    begin
                        ld <= 1'b1;
                        ld_val <= `AR_CB_TIMEOUT;
                        trun <= 1'b0;
                        state <= ST_WAIT_CLOSE;
                    end
                ST_WAIT_CLOSE:
                begin
                    close_breaker_output <= ~blocked & ~brk_close;
                    if (brk_close)
                    begin
                        ld <= 1'b1;
                        ld_val <= cur_cfg[29:15];
                        tcode <= TM_DISCR;
                        trun <= 1'b1;
                        state <= ST_DISCR;
                    end
                    else if (blocked)
                    begin
                        // Breaker supervision restarts once the block lifts
                        ld <= 1'b1;
                        ld_val <= `AR_CB_TIMEOUT;
                    end
                    else if (tdone)
                    begin
                        close_breaker_output <= 1'b0;
                        ev[`AR_IRQ_CBFAIL] <= 1'b1;
                        state <= ST_CBFAIL;
                    end
                end
                ST_DISCR:
                    if (!fault)
                    begin
                        ld <= 1'b1;
                        ld_val <= reclaim_t;
                        tcode <= TM_RECLAIM;
                        state <= ST_RECLAIM;
                    end
                    else if (tdone)
                    begin
                        open_breaker_output <= 1'b1;
                        inc_fail <= 1'b1;
                        ld <= 1'b1;
                        ld_val <= `AR_CB_TIMEOUT;
                        trun <= 1'b0;
                        state <= ST_WAIT_OPEN;
                        if (shot_ix < 3'h4 && cfg_w[nxt_i][`AR_CFG_EN_BIT])
                        begin
                            shot_ix <= shot_ix + 3'h1;
                            inc_shot <= 1'b1;
                            ev[`AR_IRQ_SHOT] <= 1'b1;
                        end
                        else
                            final_pend <= 1'b1;
                    end
                ST_RECLAIM:
                    if (tdone)
                    begin
                        shot_ix <= 3'h0;
                        trun <= 1'b0;
                        ev[`AR_IRQ_SUCCESS] <= 1'b1;
                        state <= ST_READY;
                    end
                ST_INHIBIT, ST_LOCKED:
                    if (ar_en)
                        state <= ST_READY;
                ST_FINAL, ST_CBFAIL:
                    state <= state;
                default:
                    state <= ST_INIT;
            endcase
            // Disabling mid-sequence drops both coils rather than leave one energised
            if (!ar_en && (state == ST_START || state == ST_WAIT_OPEN || state == ST_DEAD
                || state == ST_WAIT_CLOSE || state == ST_DISCR || state == ST_RECLAIM))
            begin
                open_breaker_output <= 1'b0;
                close_breaker_output <= 1'b0;
                trun <= 1'b0;
                ev[`AR_IRQ_LOCKED] <= 1'b1;
                state <= ST_LOCKED;
            end
        end
    end
endmodule // autoreclose_shot_sequencer

`default_nettype wire

// >>> autoreclose_defines.vh
// Register map, field layout, reset values and timing figures of the autoreclose sequencer
`ifndef AUTORECLOSE_DEFINES_VH
`define AUTORECLOSE_DEFINES_VH

// Byte offsets on the APB register port
`define AR_OFF_CTRL        8'h00
`define AR_OFF_STATUS      8'h04
`define AR_OFF_IRQ_STAT    8'h08
`define AR_OFF_IRQ_MASK    8'h0c
`define AR_OFF_RECLAIM     8'h10
`define AR_OFF_STARTS      8'h14
`define AR_OFF_FAILS       8'h18
`define AR_OFF_DEAD0       8'h20
`define AR_OFF_CFG0        8'h40
`define AR_OFF_SHOTCNT0    8'h90

// Control fields
`define AR_CTRL_ENABLE     0
`define AR_CTRL_BLOCK_EN   1
`define AR_CTRL_RESET      2'h1

// Status fields: [3:0] state code, [6:4] shot number, [9:8] timer code, [10] timer running
`define AR_ST_SHOT_LSB     4
`define AR_ST_TMR_LSB      8
`define AR_ST_RUN_BIT      10

// Shot configuration word: [14:0] start delay, [29:15] discrimination, [31] enable
`define AR_CFG_DISCR_LSB   15
`define AR_CFG_EN_BIT      31

// Interrupt bits
`define AR_IRQ_SHOT        0
`define AR_IRQ_SUCCESS     1
`define AR_IRQ_FINAL       2
`define AR_IRQ_CBFAIL      3
`define AR_IRQ_LOCKED      4
`define AR_IRQ_W           5

// Times in 10 ms ticks
`define AR_TICK_NS         10000000
`define AR_CLK_NS          50
`define AR_TIME_MIN        15'h0002
`define AR_TIME_MAX        15'h7530
`define AR_DEAD_RESET      15'h01f4
`define AR_RECLAIM_RESET   15'h03e8
`define AR_DELAY_RESET     15'h0002
`define AR_CB_TIMEOUT      15'h00c8

`endif

// >>> autoreclose_shot_sequencer_chk.sv
// Port-level checker for the autoreclose shot sequencer
`timescale 1ns/1ps
`default_nettype none
module autoreclose_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [3:0] req_lines,
    input wire logic       breaker_open_fb,
    input wire logic       breaker_closed_fb,
    input wire logic       open_breaker_output,
    input wire logic       close_breaker_output
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access phase not one wait state");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_COILS_EXCL: assert property (!(open_breaker_output && close_breaker_output))
        else $error("both coils driven");
    AST_TRIP_FROM_CLOSED: assert property ($rose(open_breaker_output) |-> breaker_closed_fb)
        else $error("trip issued on open breaker");
    AST_OPEN_DROPS: assert property (breaker_open_fb [*5] |-> !open_breaker_output)
        else $error("trip kept after breaker opened");
    AST_CLOSE_AFTER_OPEN: assert property ($rose(close_breaker_output) |-> breaker_open_fb)
        else $error("close issued on closed breaker");
    AST_CLOSE_DROPS: assert property (breaker_closed_fb [*5] |-> !close_breaker_output)
        else $error("close kept after breaker closed");
    AST_TRIP_ON_FAULT: assert property ($rose(open_breaker_output) |->
        $past(req_lines, 2) != 4'h0 || $past(req_lines, 3) != 4'h0 || $past(req_lines, 4) != 4'h0)
        else $error("trip without fault");

    COV_TRIP: cover property ($rose(open_breaker_output));
    COV_CLOSE: cover property ($rose(close_breaker_output));
    COV_ERR: cover property (pslverr);
endmodule // autoreclose_chk

bind autoreclose_shot_sequencer autoreclose_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .req_lines(req_lines), .breaker_open_fb(breaker_open_fb),
    .breaker_closed_fb(breaker_closed_fb), .open_breaker_output(open_breaker_output),
    .close_breaker_output(close_breaker_output));
`default_nettype wire

// >>> breaker_model.sv
// Behavioural circuit breaker answering the trip and close coils
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
    parameter int DLY = 12
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic open_cmd,
    input  wire logic close_cmd,
    output var  logic open_fb,
    output var  logic closed_fb
);
    int cnt;
    // Contacts move only after a mechanical delay, never at once
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            open_fb <= 1'b0;
            closed_fb <= 1'b1;
        end
        else if ((open_cmd && closed_fb) || (close_cmd && open_fb))
        begin
            cnt <= cnt + 1;
            if (cnt == DLY)
            begin
                cnt <= 0;
                open_fb <= closed_fb;
                closed_fb <= open_fb;
            end
        end
        else
            cnt <= 0;
    end
endmodule // breaker_model
`default_nettype wire

// >>> test_autoreclose_shot_sequencer.sv
// Testbench for the autoreclose shot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defines.vh"
module test_autoreclose_shot_sequencer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  req_lines;
    logic        blk, open_o, close_o, open_fb, closed_fb;
    int          fail_count, n_tests, cyc;
    localparam logic [31:0] CFG_ON = 32'h80010002;

    autoreclose_shot_sequencer #(.TICK_CYCLES(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_lines(req_lines),
        .breaker_open_fb(open_fb), .breaker_closed_fb(closed_fb),
        .close_block_input(blk), .open_breaker_output(open_o),
        .close_breaker_output(close_o), .irq(irq));
    breaker_model i_brk (.clk(pclk), .rst_n(presetn), .open_cmd(open_o),
        .close_cmd(close_o), .open_fb(open_fb), .closed_fb(closed_fb));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    // Polls a coil output; a bound that runs out is a mismatch
    task automatic wait_pin(input logic w, input logic v, input int lim);
        int n;
        n = 0;
        while (((w ? close_o : open_o) !== v) && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n < lim, 1);
    endtask

    task automatic wait_state(input logic [3:0] s);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `AR_OFF_STATUS, 32'h0);
            n++;
        end while (rd[3:0] !== s && n < 100);
        chk(n < 100, 1);
    endtask

    task automatic reset_values();
        rdchk(`AR_OFF_RECLAIM, 32'h3e8, 32'h7fff);
        rdchk(`AR_OFF_DEAD0, 32'h1f4, 32'h7fff);
        rdchk(8'h30, 32'h1f4, 32'h7fff);
        rdchk(`AR_OFF_CFG0, 32'h00010002, 32'hffffffff);
        rdchk(`AR_OFF_STATUS, 32'h12, 32'h7f);
        apb(1'b0, 8'h1c, 32'h0);
        chk(err, 1);
        apb(1'b1, `AR_OFF_RECLAIM, 32'h0);
        rdchk(`AR_OFF_RECLAIM, 32'h2, 32'h7fff);
        apb(1'b1, `AR_OFF_RECLAIM, 32'h7fff);
        rdchk(`AR_OFF_RECLAIM, 32'h7530, 32'h7fff);
        apb(1'b1, `AR_OFF_RECLAIM, 32'h2);
    endtask

    task automatic two_shots();
        apb(1'b1, `AR_OFF_DEAD0, 32'h2);
        apb(1'b1, 8'h24, 32'h2);
        apb(1'b1, `AR_OFF_CFG0, CFG_ON);
        apb(1'b1, 8'h44, CFG_ON);
        apb(1'b1, `AR_OFF_IRQ_MASK, 32'h2);
        req_lines <= 4'h1;
        wait_pin(1'b0, 1'b1, 100);
        rdchk(`AR_OFF_STATUS, 32'h013, 32'h47f);
        wait_pin(1'b0, 1'b0, 40);
        rdchk(`AR_OFF_STATUS, 32'h614, 32'h77f);
        wait_pin(1'b1, 1'b1, 60);
        wait_pin(1'b1, 1'b0, 40);
        wait_pin(1'b0, 1'b1, 60);
        wait_pin(1'b0, 1'b0, 40);
        rdchk(`AR_OFF_STATUS, 32'h624, 32'h77f);
        wait_pin(1'b1, 1'b1, 60);
        req_lines <= 4'h0;
        wait_pin(1'b1, 1'b0, 40);
        wait_state(4'h1);
        wait_state(4'h2);
        chk(rd & 32'h7f, 32'h12);
        chk(open_o, 0);
        rdchk(`AR_OFF_STARTS, 32'h1, 32'hffff);
        rdchk(`AR_OFF_FAILS, 32'h1, 32'hffff);
        rdchk(`AR_OFF_SHOTCNT0, 32'h1, 32'hffff);
        rdchk(8'h94, 32'h1, 32'hffff);
        chk(irq, 1);
        rdchk(`AR_OFF_IRQ_STAT, 32'h3, 32'h3);
        apb(1'b1, `AR_OFF_IRQ_STAT, 32'h1f);
        apb(1'b1, `AR_OFF_STARTS, 32'h0);
        chk(irq, 0);
        rdchk(`AR_OFF_STARTS, 32'h0, 32'hffff);
    endtask

    task automatic block_then_final();
        apb(1'b1, `AR_OFF_CTRL, 32'h3);
        apb(1'b1, 8'h44, 32'h0);
        blk <= 1'b1;
        req_lines <= 4'h1;
        wait_pin(1'b0, 1'b1, 100);
        wait_pin(1'b0, 1'b0, 40);
        // Well past the dead time, so only the block can hold the close back
        repeat (60) @(posedge pclk);
        chk(close_o, 0);
        blk <= 1'b0;
        wait_pin(1'b1, 1'b1, 8);
        wait_pin(1'b1, 1'b0, 40);
        wait_pin(1'b0, 1'b1, 60);
        wait_pin(1'b0, 1'b0, 40);
        wait_state(4'h7);
        repeat (100) @(posedge pclk);
        chk(close_o, 0);
        rdchk(`AR_OFF_FAILS, 32'h2, 32'hffff);
    endtask

    // Only a reset leaves final trip; then disable and re-enable
    task automatic reset_inhibit();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`AR_OFF_STATUS, 32'h12, 32'h7f);
        apb(1'b1, `AR_OFF_CTRL, 32'h0);
        wait_state(4'h9);
        apb(1'b1, `AR_OFF_CTRL, 32'h1);
        wait_state(4'h2);
    endtask

    initial
    begin
        {psel, penable, pwrite, blk} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        req_lines = 4'h0;
        presetn = 1'b0;
        {fail_count, n_tests, cyc} = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        two_shots();
        block_then_final();
        reset_inhibit();
        finish_test();
    end
endmodule // test_autoreclose_shot_sequencer
`default_nettype wire
